// *** hdl/rtc_defs.svh ***
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// ----------------------------------------------------------------
// register indices on the register port
// ----------------------------------------------------------------
`define RTC_IDX_RATE_OSC      2'h0
`define RTC_IDX_MODE_ENABLE   2'h1
`define RTC_IDX_IRQ_FLAG      2'h2
`define RTC_IDX_BACKUP_VALID  2'h3

// ----------------------------------------------------------------
// rate_oscillator_control fields
// ----------------------------------------------------------------
`define RTC_A_UIP             7
`define RTC_A_OSC_HI          6
`define RTC_A_OSC_LO          4
`define RTC_A_RS_HI           3
`define RTC_A_RS_LO           0

// ----------------------------------------------------------------
// mode_enable_control fields
// ----------------------------------------------------------------
`define RTC_B_SET             7
`define RTC_B_PIE             6
`define RTC_B_AIE             5
`define RTC_B_UIE             4
`define RTC_B_SQUARE_WAVE_ENABLE            3
`define RTC_B_DM              2
`define RTC_B_H24             1
`define RTC_B_DSE             0

// ----------------------------------------------------------------
// interrupt_flag_status / backup_valid_status fields
// ----------------------------------------------------------------
`define RTC_C_COMBINED_REQUEST_FLAG            7
`define RTC_C_PF              6
`define RTC_C_AF              5
`define RTC_C_UF              4
`define RTC_D_VRT             7

// ----------------------------------------------------------------
// power-on values of battery-backed bits
// ----------------------------------------------------------------
`define RTC_POR_OSC           3'h0
`define RTC_POR_RS            4'h0
`define RTC_POR_MODE          8'h00

// ----------------------------------------------------------------
// timing, in ticks of the 32.768 kHz time base
// ----------------------------------------------------------------
`define RTC_TIMEBASE_HZ       32768
`define RTC_UIP_LEAD_US       244
`define RTC_UIP_LEAD_TICKS    ((`RTC_UIP_LEAD_US * `RTC_TIMEBASE_HZ + 999999) / 1000000)
`define RTC_DIV_STAGES        15
`define RTC_UPDATE_PRE        15'h3fff
`define RTC_ALARM_DONTCARE    7

`endif

// *** hdl/rtc_pkg.sv ***
`default_nettype none
package rtc_pkg;
  typedef logic [1:0] rtc_regsel_t;
  typedef enum logic [2:0] {
    OSC_OFF  = 3'b001,
    OSC_RUN  = 3'b010,
    OSC_HOLD = 3'b100
  } rtc_osc_mode_t;
endpackage : rtc_pkg
`default_nettype wire

// *** hdl/rtc_divider.sv ***
`include "rtc_defs.svh"
`default_nettype none
module rtc_divider #(
  parameter int STAGES = `RTC_DIV_STAGES
) (
  input  wire logic              mclk,
  input  wire logic              powerOnReset_n,
  input  wire logic              ce,
  input  wire logic              step,
  input  wire logic              hold,
  input  wire logic              clear,
  output logic [STAGES-1:0]      count
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (STAGES != `RTC_DIV_STAGES) begin : g_bad_stages
    $error("rtc_divider: tap decode needs exactly 15 stages");
  end

  // ----------------------------------------------------------------
  // ripple-equivalent chain as one binary counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      count <= '0;
    end else if (ce) begin
      if (hold || clear) begin
        count <= '0;
      end else if (step) begin
        count <= count + {{(STAGES-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule : rtc_divider
`default_nettype wire

// *** hdl/rtc_ctrl_status.sv ***
`include "rtc_defs.svh"
`default_nettype none
module rtc_ctrl_status
  import rtc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        powerOnReset_n,
  input  wire logic        ce,
  input  wire logic        timeBase32k,
  input  wire logic        backupGood,
  input  wire rtc_regsel_t regSel,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic [7:0]  wrData,
  input  wire logic [7:0]  curSeconds,
  input  wire logic [7:0]  curMinutes,
  input  wire logic [7:0]  curHours,
  input  wire logic [7:0]  alarmSeconds,
  input  wire logic [7:0]  alarmMinutes,
  input  wire logic [7:0]  alarmHours,
  output logic [7:0]       rdData,
  output logic             irq_n,
  output logic             square_wave_pin,
  output logic             oscRun,
  output logic             updateStrobe,
  output logic             freezeUpdates,
  output logic             binaryFormat,
  output logic             hour24Mode,
  output logic             daylightSaving
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic rtc_osc_mode_t oscDecode(input logic [2:0] osc);
    if (osc == 3'b010) begin
      return OSC_RUN;
    end else if (osc[2:1] == 2'b11) begin
      return OSC_HOLD;
    end
    return OSC_OFF;
  endfunction : oscDecode

  // codes 1 and 2 reuse the 256 Hz and 128 Hz stages
  function automatic logic [3:0] tapIndex(input logic [3:0] rs);
    unique case (rs)
      4'h1:    return 4'h6;
      4'h2:    return 4'h7;
      4'h0:    return 4'h0;
      default: return rs - 4'h2;
    endcase
  endfunction : tapIndex

  function automatic logic alarmByteHit(input logic [7:0] cur, input logic [7:0] alm);
    return alm[`RTC_ALARM_DONTCARE] || (cur == alm);
  endfunction : alarmByteHit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tbSync_r;
  logic [1:0] vrtSync_r;
  logic       tbPrev_r;

  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      tbSync_r  <= 2'h0;
      vrtSync_r <= 2'h0;
      tbPrev_r  <= 1'b0;
    end else if (ce) begin
      tbSync_r  <= {tbSync_r[0], timeBase32k};
      vrtSync_r <= {vrtSync_r[0], backupGood};
      tbPrev_r  <= tbSync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // battery-backed control: only power-on clears these
  // ----------------------------------------------------------------
  logic [2:0] osc_r;
  logic [3:0] rate_r;
  logic       freeze_r;
  logic       binFmt_r;
  logic       h24_r;
  logic       dse_r;
  logic       divClear;
  rtc_osc_mode_t oscMode;
  logic       wrA;
  logic       wrB;
  logic       rdC;

  assign wrA     = wrEn && (regSel == `RTC_IDX_RATE_OSC);
  assign wrB     = wrEn && (regSel == `RTC_IDX_MODE_ENABLE);
  assign rdC     = rdEn && (regSel == `RTC_IDX_IRQ_FLAG);
  assign oscMode = oscDecode(osc_r);
  // restart the chain on entry to run so the first update is half a second away
  assign divClear = wrA && (oscDecode(wrData[`RTC_A_OSC_HI:`RTC_A_OSC_LO]) == OSC_RUN)
                    && (oscMode != OSC_RUN);

  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      osc_r  <= `RTC_POR_OSC;
      rate_r <= `RTC_POR_RS;
    end else if (ce && wrA) begin
      osc_r  <= wrData[`RTC_A_OSC_HI:`RTC_A_OSC_LO];
      rate_r <= wrData[`RTC_A_RS_HI:`RTC_A_RS_LO];
    end
  end

  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      freeze_r <= 1'(`RTC_POR_MODE >> `RTC_B_SET);
      binFmt_r <= 1'b0;
      h24_r    <= 1'b0;
      dse_r    <= 1'b0;
    end else if (ce && wrB) begin
      freeze_r <= wrData[`RTC_B_SET];
      binFmt_r <= wrData[`RTC_B_DM];
      h24_r    <= wrData[`RTC_B_H24];
      dse_r    <= wrData[`RTC_B_DSE];
    end
  end

  // ----------------------------------------------------------------
  // divider chain, rate selector, update timing
  // ----------------------------------------------------------------
  logic [`RTC_DIV_STAGES-1:0] divCount;
  logic       tbStep;
  logic       tap;
  logic       tapPrev_r;
  logic       tapEdge;
  logic       updTick;
  logic       uipWindow;
  logic       uip_r;

  // one divider step per rising edge of the 32.768 kHz base
  assign tbStep = (oscMode == OSC_RUN) && tbSync_r[1] && !tbPrev_r;

  rtc_divider #(
    .STAGES (`RTC_DIV_STAGES)
  ) u_divider (
    .mclk           (mclk),
    .powerOnReset_n (powerOnReset_n),
    .ce             (ce),
    .step           (tbStep),
    .hold           (oscMode != OSC_RUN),
    .clear          (divClear),
    .count          (divCount)
  );

  assign tap     = (rate_r != 4'h0) && divCount[tapIndex(rate_r)];
  assign tapEdge = tap && !tapPrev_r;
  // stage 14 rising is the once-per-second update point
  assign updTick = tbStep && (divCount == `RTC_UPDATE_PRE);
  assign uipWindow = (oscMode == OSC_RUN) && !divCount[`RTC_DIV_STAGES-1]
                     && (divCount[`RTC_DIV_STAGES-2:0] >= 14'(32'h0000_4000 - `RTC_UIP_LEAD_TICKS));

  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      tapPrev_r <= 1'b0;
    end else if (ce) begin
      tapPrev_r <= tap;
    end
  end

  // not on reset_n: the pending indication survives a bus reset
  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      uip_r <= 1'b0;
    end else if (ce) begin
      uip_r <= uipWindow && !freeze_r && !(wrB && wrData[`RTC_B_SET]);
    end
  end

  // ----------------------------------------------------------------
  // enables cleared by reset_n
  // ----------------------------------------------------------------
  logic pie_r;
  logic aie_r;
  logic uie_r;
  logic square_wave_enable_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pie_r  <= 1'b0;
      aie_r  <= 1'b0;
      uie_r  <= 1'b0;
      square_wave_enable_r <= 1'b0;
    end else if (ce && wrB) begin
      pie_r  <= wrData[`RTC_B_PIE];
      aie_r  <= wrData[`RTC_B_AIE];
      uie_r  <= wrData[`RTC_B_UIE] && !(wrData[`RTC_B_SET] && !freeze_r);
      square_wave_enable_r <= wrData[`RTC_B_SQUARE_WAVE_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // event flags, clear on read of the flag register
  // ----------------------------------------------------------------
  logic pf_r;
  logic af_r;
  logic uf_r;
  logic pfSet;
  logic afSet;
  logic ufSet;
  logic irqAny;

  assign pfSet = tapEdge;
  assign afSet = updTick && alarmByteHit(curSeconds, alarmSeconds)
                 && alarmByteHit(curMinutes, alarmMinutes)
                 && alarmByteHit(curHours, alarmHours);
  assign ufSet = updTick;
  assign irqAny = (pf_r && pie_r) || (af_r && aie_r) || (uf_r && uie_r);

  // set beats the read clear, so an event during a read posts afterwards
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pf_r <= 1'b0;
      af_r <= 1'b0;
      uf_r <= 1'b0;
    end else if (ce) begin
      pf_r <= pfSet || (pf_r && !rdC);
      af_r <= afSet || (af_r && !rdC);
      uf_r <= ufSet || (uf_r && !rdC);
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in one edge so it stays stable
  // ----------------------------------------------------------------
  logic [7:0] rdMux;

  always_comb begin
    rdMux = 8'h00;
    unique case (regSel)
      `RTC_IDX_RATE_OSC:     rdMux = {uip_r, osc_r, rate_r};
      `RTC_IDX_MODE_ENABLE:  rdMux = {freeze_r, pie_r, aie_r, uie_r, square_wave_enable_r, binFmt_r, h24_r, dse_r};
      `RTC_IDX_IRQ_FLAG:     rdMux = {irqAny, pf_r, af_r, uf_r, 4'h0};
      `RTC_IDX_BACKUP_VALID: rdMux = {vrtSync_r[1], 7'h00};
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= 8'h00;
    end else if (ce && rdEn) begin
      rdData <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_n           <= 1'b1;
      square_wave_pin <= 1'b0;
      updateStrobe    <= 1'b0;
    end else if (ce) begin
      irq_n           <= !irqAny;
      square_wave_pin <= square_wave_enable_r && tap;
      updateStrobe    <= updTick && !freeze_r;
    end
  end

  always_ff @(posedge mclk or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      oscRun         <= 1'b0;
      freezeUpdates  <= 1'b0;
      binaryFormat   <= 1'b0;
      hour24Mode     <= 1'b0;
      daylightSaving <= 1'b0;
    end else if (ce) begin
      oscRun         <= (oscMode != OSC_OFF);
      freezeUpdates  <= freeze_r;
      binaryFormat   <= binFmt_r;
      hour24Mode     <= h24_r;
      daylightSaving <= dse_r;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_readFlags;
    ce && rdC;
  endsequence

  sequence s_freezeRise;
    ce && wrB && wrData[`RTC_B_SET] && !freeze_r;
  endsequence

  a_irq_mirror: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    ce |=> (irq_n == !$past(irqAny)))
    else $error("interrupt output does not follow gated flags");

  a_read_clears: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    s_readFlags ##0 !pfSet ##0 !afSet ##0 !ufSet |=> !pf_r && !af_r && !uf_r)
    else $error("flag read did not clear flags");

  a_event_kept: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    s_readFlags ##0 pfSet |=> pf_r && (rdData[`RTC_C_PF] == $past(pf_r)))
    else $error("event during flag read was lost");

  a_freeze_uie: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    s_freezeRise |=> !uie_r && freeze_r)
    else $error("freeze rise did not clear update enable");

  a_freeze_block: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    ce && freeze_r |=> !updateStrobe && !uip_r)
    else $error("update transfer or pending flag while frozen");

  a_uip_lead: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    $rose(updateStrobe) |-> $past(uip_r, 2))
    else $error("update transfer without pending indication");

  a_sqw_gate: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    ce && (!square_wave_enable_r || rate_r == 4'h0) |=> !square_wave_pin)
    else $error("square wave pin not held low");

  a_low_nibble: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    s_readFlags |=> rdData[3:0] == 4'h0)
    else $error("flag register low bits not zero");

  a_backup_zero: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    ce && rdEn && regSel == `RTC_IDX_BACKUP_VALID |=> rdData == {$past(vrtSync_r[1]), 7'h00})
    else $error("backup valid register read wrong");

  a_osc_hold: assert property (@(posedge mclk) disable iff (!reset_n || !powerOnReset_n)
    ce && oscMode != OSC_RUN |=> divCount == '0)
    else $error("divider not held while oscillator not running");
endmodule : rtc_ctrl_status
`default_nettype wire

// *** testbench/rtc_host_model.sv ***
`default_nettype none
module rtc_host_model
  import rtc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdData,
  output var rtc_regsel_t regSel,
  output logic            wrEn,
  output logic            rdEn,
  output logic [7:0]      wrData
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    regSel = 2'h0;
    wrEn   = 1'b0;
    rdEn   = 1'b0;
    wrData = 8'h00;
  end

  // ----------------------------------------------------------------
  // register port cycles
  // ----------------------------------------------------------------
  // idle bus shows inverted values, so a stale index or byte never looks valid
  task automatic bus_write(input rtc_regsel_t idx, input logic [7:0] data);
    @(posedge mclk);
    #1;
    regSel = idx;
    wrData = data;
    wrEn   = 1'b1;
    @(posedge mclk);
    #1;
    wrEn   = 1'b0;
    regSel = ~idx;
    wrData = ~data;
  endtask : bus_write

  task automatic bus_read(input rtc_regsel_t idx, output logic [7:0] data);
    @(posedge mclk);
    #1;
    regSel = idx;
    rdEn   = 1'b1;
    @(posedge mclk);
    #1;
    rdEn   = 1'b0;
    regSel = ~idx;
    data   = rdData;
  endtask : bus_read
endmodule : rtc_host_model
`default_nettype wire

// *** testbench/rtc_ctrl_status_tb_top.sv ***
`default_nettype none
module rtc_ctrl_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 mclk;
  logic                 reset_n;
  logic                 powerOnReset_n;
  logic                 timeBase32k;
  logic                 backupGood;
  rtc_pkg::rtc_regsel_t regSel;
  logic                 wrEn;
  logic                 rdEn;
  logic [7:0]           wrData;
  logic [7:0]           rdData;
  logic [7:0]           rd;
  logic                 irq_n;
  logic                 square_wave_pin;
  logic                 oscRun;
  logic                 updateStrobe;
  logic                 freezeUpdates;
  logic                 binaryFormat;
  logic                 hour24Mode;
  logic                 daylightSaving;
  logic                 ce;
  logic [7:0]           alarmHours;
  int                   fail_count = 0;
  int                   total_checks = 0;
  int                   cyc = 0;

  rtc_ctrl_status i_rtc_ctrl_status (
    .mclk(mclk), .reset_n(reset_n), .powerOnReset_n(powerOnReset_n), .ce(ce),
    .timeBase32k(timeBase32k), .backupGood(backupGood), .regSel(regSel), .wrEn(wrEn),
    .rdEn(rdEn), .wrData(wrData), .curSeconds(8'h00), .curMinutes(8'h00), .curHours(8'h00),
    .alarmSeconds(8'h00), .alarmMinutes(8'h80), .alarmHours(alarmHours), .rdData(rdData),
    .irq_n(irq_n), .square_wave_pin(square_wave_pin), .oscRun(oscRun),
    .updateStrobe(updateStrobe), .freezeUpdates(freezeUpdates), .binaryFormat(binaryFormat),
    .hour24Mode(hour24Mode), .daylightSaving(daylightSaving));

  rtc_host_model i_rtc_host_model (
    .mclk(mclk), .rdData(rdData), .regSel(regSel), .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData));

  // ----------------------------------------------------------------
  // clocks and helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // time base sped up to 2 mclk per tick; edges fall on falling mclk edges only
  initial begin
    timeBase32k = 1'b0;
    forever #10 timeBase32k = ~timeBase32k;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (square_wave_pin !== v && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : wait_pin

  task automatic rd_chk(input logic [1:0] idx, input logic [7:0] exp);
    i_rtc_host_model.bus_read(idx, rd);
    check(rd, exp);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_status_regs();
    rd_chk(2'h3, 8'h80);
    rd_chk(2'h2, 8'h00);
    i_rtc_host_model.bus_write(2'h3, 8'h7f);
    i_rtc_host_model.bus_write(2'h2, 8'h0f);
    rd_chk(2'h3, 8'h80);
    rd_chk(2'h2, 8'h00);
    backupGood = 1'b0;
    wait_cyc(4);
    rd_chk(2'h3, 8'h00);
    backupGood = 1'b1;
  endtask : t_status_regs

  task automatic t_modes_reset();
    i_rtc_host_model.bus_write(2'h1, 8'h10);
    i_rtc_host_model.bus_write(2'h1, 8'h90);
    rd_chk(2'h1, 8'h80);
    check(freezeUpdates, 1'b1);
    i_rtc_host_model.bus_write(2'h1, 8'h7f);
    i_rtc_host_model.bus_write(2'h0, 8'ha3);
    rd_chk(2'h0, 8'h23);
    check({binaryFormat, hour24Mode, daylightSaving}, 3'h7);
    reset_n = 1'b0;
    wait_cyc(2);
    reset_n = 1'b1;
    rd_chk(2'h0, 8'h23);
    rd_chk(2'h1, 8'h07);
    check(square_wave_pin, 1'b0);
  endtask : t_modes_reset

  task automatic t_rates();
    logic [3:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h1, 4'h2};
    int         t0;
    logic       hi;
    i_rtc_host_model.bus_write(2'h1, 8'h08);
    foreach (codes[i]) begin
      i_rtc_host_model.bus_write(2'h0, {4'h2, codes[i]});
      wait_pin(1'b0);
      wait_pin(1'b1);
      t0 = cyc;
      wait_pin(1'b0);
      wait_pin(1'b1);
      check(cyc - t0, codes[i] >= 4'h3 ? 1 << codes[i] : 128 << codes[i]);
    end
    i_rtc_host_model.bus_write(2'h0, 8'h20);
    wait_cyc(100);
    check(square_wave_pin, 1'b0);
    i_rtc_host_model.bus_write(2'h0, 8'h23);
    i_rtc_host_model.bus_write(2'h1, 8'h00);
    hi = 1'b0;
    repeat (100) begin
      wait_cyc(1);
      hi = hi | square_wave_pin;
    end
    check(hi, 1'b0);
  endtask : t_rates

  task automatic t_periodic();
    i_rtc_host_model.bus_read(2'h2, rd);
    wait_cyc(40);
    check(irq_n, 1'b1);
    rd_chk(2'h2, 8'h40);
    i_rtc_host_model.bus_write(2'h1, 8'h40);
    wait_cyc(40);
    check(irq_n, 1'b0);
    rd_chk(2'h2, 8'hc0);
    i_rtc_host_model.bus_write(2'h1, 8'h00);
    i_rtc_host_model.bus_write(2'h0, 8'h63);
    i_rtc_host_model.bus_read(2'h2, rd);
    i_rtc_host_model.bus_read(2'h2, rd);
    wait_cyc(100);
    rd_chk(2'h2, 8'h00);
    check(oscRun, 1'b1);
    i_rtc_host_model.bus_write(2'h0, 8'h03);
    wait_cyc(2);
    check(oscRun, 1'b0);
    // clock enable low: the write must not land
    ce = 1'b0;
    i_rtc_host_model.bus_write(2'h1, 8'h7f);
    ce = 1'b1;
    rd_chk(2'h1, 8'h00);
  endtask : t_periodic

  task automatic t_update();
    int   t0;
    int   n;
    logic hi;
    i_rtc_host_model.bus_write(2'h1, 8'h10);
    i_rtc_host_model.bus_write(2'h0, 8'h20);
    t0 = cyc;
    i_rtc_host_model.bus_read(2'h2, rd);
    while (cyc < t0 + 32728) @(posedge mclk);
    rd_chk(2'h0, 8'h20);
    while (cyc < t0 + 32758) @(posedge mclk);
    rd_chk(2'h0, 8'ha0);
    n = 0;
    while (updateStrobe !== 1'b1 && n < 200) begin
      wait_cyc(1);
      n++;
    end
    check((cyc - t0 >= 32764) && (cyc - t0 <= 32774), 1'b1);
    wait_cyc(3);
    check(irq_n, 1'b0);
    rd_chk(2'h2, 8'hb0);
    i_rtc_host_model.bus_write(2'h1, 8'h90);
    rd_chk(2'h1, 8'h80);
    rd_chk(2'h0, 8'h20);
    // frozen, hours byte off: update flag still posts, no transfer, no alarm
    alarmHours = 8'h05;
    i_rtc_host_model.bus_write(2'h0, 8'h60);
    i_rtc_host_model.bus_write(2'h0, 8'h20);
    t0 = cyc;
    hi = 1'b0;
    while (cyc < t0 + 32790) begin
      wait_cyc(1);
      hi = hi | updateStrobe;
    end
    check(hi, 1'b0);
    rd_chk(2'h2, 8'h10);
  endtask : t_update

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    reset_n        = 1'b0;
    powerOnReset_n = 1'b0;
    backupGood     = 1'b1;
    ce             = 1'b1;
    alarmHours     = 8'hc5;
    repeat (6) @(posedge mclk);
    #1;
    reset_n        = 1'b1;
    powerOnReset_n = 1'b1;
    // let the pin synchronisers fill before the first read
    wait_cyc(3);
    t_status_regs();
    t_modes_reset();
    t_rates();
    t_periodic();
    t_update();
    complete_run();
  end

  // expected run is about 68k cycles
  initial begin
    #950000;
    fail_count++;
    complete_run();
  end
endmodule : rtc_ctrl_status_tb_top
`default_nettype wire
